/* shared/lcj_pkg.sv */
// constants, types and register map of the limit comparator
// assumes one 100 MHz clock and an AHB-Lite master
// Behaviour
// - classify result over_max, pass or under_min
// - separate limit pairs, judged apart, AND output
// - disabled limit is skipped in comparison
// - both limits disabled: no judgment shown
// - overflow gives over_max, underflow under_min first
// - not above lower limit gives under_min
// - not below upper gives over_max, else pass
// - stored limits are never range checked
// - limits are raw counts, compared to counts
// - comparator mode judges after every measurement
// - comparator mode forces held ranging
// - comparator mode survives power loss
// - power loss mid-edit discards the edit
// - edit steps four limits, confirm stores, advances
// - skip advances without storing
// - two second end hold sets disabled marker
// - comparator mode rejects condition changes except trigger and slot load
// - manual shot only in outside_trigger, one measurement
// - 99 slots hold conditions, limits, compensation
// - slots 01..99, unused offered first, overwrite allowed
// - cancel after choosing slot writes nothing
// - internal trigger runs continuously, external once each
package lcj_pkg;
   localparam int COUNT_W = 17;
   localparam int SLOT_W = 7;
   localparam int SLOT_FIRST = 1;
   localparam int SLOT_COUNT = 99;
   localparam int HOLD_TIME_MS = 2000;
   localparam int CLK_KHZ = 100000;
   localparam int unsigned HOLD_CYCLES = HOLD_TIME_MS * CLK_KHZ;
   // register byte offsets
   localparam logic [7:0] OFS_CFG = 8'h00;
   localparam logic [7:0] OFS_CMD = 8'h04;
   localparam logic [7:0] OFS_EDIT = 8'h08;
   localparam logic [7:0] OFS_SLOT = 8'h0c;
   localparam logic [7:0] OFS_COMP = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;
   localparam logic [7:0] OFS_LIM0 = 8'h18;
   localparam logic [7:0] OFS_LIM3 = 8'h24;
   localparam logic [7:0] OFS_JUDGE = 8'h28;
   // command bits
   localparam int CMD_MODE = 0;
   localparam int CMD_TRIG = 1;
   localparam int CMD_SHOT = 2;
   localparam int CMD_EDIT = 3;
   localparam int CMD_CONFIRM = 4;
   localparam int CMD_SKIP = 5;
   localparam int CMD_SAVE = 6;
   localparam int CMD_LOAD = 7;
   localparam int CMD_CANCEL = 8;
   localparam int STAT_REJECT = 8;
   localparam int PIN_TRIG_N = 0;
   localparam int PIN_MOVE = 1;
   localparam int PIN_END = 2;
   localparam int PIN_PFAIL = 3;
   localparam logic [3:0] PIN_RESET = 4'h1;
   typedef struct packed {
      logic off;
      logic [COUNT_W-1:0] val;
   } lcj_limit_type;
   typedef struct packed {
      logic ovf;
      logic unf;
      logic [COUNT_W-1:0] count;
   } lcj_result_type;
   typedef struct packed {
      logic over_max;
      logic pass;
      logic under_min;
   } lcj_judg_type;
   typedef struct packed {
      lcj_judg_type main_j;
      lcj_judg_type sec_j;
      logic all_pass;
   } lcj_port_type;
   typedef struct packed {
      logic outside_trigger;
      logic auto_range;
   } lcj_cfg_type;
   typedef struct packed {
      lcj_cfg_type cfg;
      logic [31:0] comp;
      lcj_limit_type [3:0] lim;
   } lcj_cond_type;
   localparam lcj_limit_type LIMIT_OFF = '{off: 1'b1, val: '0};
   typedef enum logic [5:0] {
      st_idle = 6'h01,
      st_main_upper_edit = 6'h02,
      st_main_lower_edit = 6'h04,
      st_second_upper_edit = 6'h08,
      st_second_lower_edit = 6'h10,
      st_save = 6'h20
   } lcj_state_type;
endpackage

/* hdl/lcj_judge.sv */
// one parameter's three-way judgment, purely combinational
// assumes result and limits come from the same clock domain
`timescale 1ns/100ps
module lcj_judge (
   // compared result and its two bounds
   input lcj_pkg::lcj_result_type res,
   input lcj_pkg::lcj_limit_type upper,
   input lcj_pkg::lcj_limit_type lower,
   // judgment
   output lcj_pkg::lcj_judg_type judg,
   output logic active
);
   import lcj_pkg::*;
   always_comb begin
      judg = '0;
      active = !(upper.off && lower.off);
      if (active) begin
         // order of checks sets the priority
         if (res.ovf) begin
            judg.over_max = 1'b1;
         end else if (res.unf) begin
            judg.under_min = 1'b1;
         end else if (!lower.off && !(res.count > lower.val)) begin
            judg.under_min = 1'b1;
         end else if (!upper.off && !(res.count < upper.val)) begin
            judg.over_max = 1'b1;
         end else begin
            judg.pass = 1'b1;
         end
      end
   end
endmodule

/* hdl/lcj_top.sv */
// limit comparator: AHB-Lite registers, limit edit, slot store,
// trigger control and the parallel judgment port
// assumes the measurement engine runs on hclk; key and trigger pins are async
//
// Local design decisions: the AHB-Lite register port and the address map.
`timescale 1ns/100ps
module lcj_top #(
   parameter int unsigned HOLD_CYCLES = lcj_pkg::HOLD_CYCLES
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // measurement engine
   input wire lcj_pkg::lcj_result_type meas_main,
   input wire lcj_pkg::lcj_result_type meas_sec,
   input wire logic meas_done,
   output logic meas_start,
   output logic range_auto_eff,
   // panel and rear pins
   input wire logic outside_trigger_n,
   input wire logic key_move,
   input wire logic cursor_at_end,
   input wire logic power_fail,
   // parallel judgment port
   output lcj_pkg::lcj_port_type parallel_judgment_port
);
   import lcj_pkg::*;

   // pin synchronisers
   logic [3:0] sy1_reg;
   logic [3:0] sy2_reg;
   logic trig_prev_reg;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sy1_reg <= PIN_RESET;
         sy2_reg <= PIN_RESET;
         trig_prev_reg <= 1'b1;
      end else begin
         sy1_reg <= {power_fail, cursor_at_end, key_move, outside_trigger_n};
         sy2_reg <= sy1_reg;
         trig_prev_reg <= sy2_reg[PIN_TRIG_N];
      end
   end
   logic pf_s;
   logic trig_edge;
   assign pf_s = sy2_reg[PIN_PFAIL];
   // negative pulse from the handler starts one measurement
   assign trig_edge = trig_prev_reg && !sy2_reg[PIN_TRIG_N];

   // ahb-lite slave, zero wait, always okay
   logic wr_pend_reg;
   logic [7:0] wr_addr_reg;
   logic [31:0] hrdata_reg;
   logic [31:0] rd_word;
   logic addr_ok;
   assign addr_ok = hsel && hready && htrans[1];
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_reg;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= '0;
      end else begin
         wr_pend_reg <= addr_ok && hwrite;
         wr_addr_reg <= haddr[7:0];
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_reg <= '0;
      end else if (addr_ok && !hwrite) begin
         hrdata_reg <= rd_word;
      end
   end

   logic w_cfg, w_edit, w_slot, w_comp, w_stat;
   logic [8:0] cmd;
   assign w_cfg = wr_pend_reg && wr_addr_reg == OFS_CFG;
   assign w_edit = wr_pend_reg && wr_addr_reg == OFS_EDIT;
   assign w_slot = wr_pend_reg && wr_addr_reg == OFS_SLOT;
   assign w_comp = wr_pend_reg && wr_addr_reg == OFS_COMP;
   assign w_stat = wr_pend_reg && wr_addr_reg == OFS_STATUS;
   assign cmd = (wr_pend_reg && wr_addr_reg == OFS_CMD) ? hwdata[8:0] : '0;

   // control state
   lcj_state_type state_reg;
   lcj_cfg_type cfg_reg;
   logic comp_mode_reg;
   logic edit_end_reg;
   lcj_limit_type [3:0] lim_reg;
   lcj_limit_type edit_reg;
   logic [31:0] comp_reg;
   logic [SLOT_W-1:0] slot_reg;
   logic [SLOT_COUNT:SLOT_FIRST] used_reg;
   lcj_cond_type slot_mem [SLOT_FIRST:SLOT_COUNT];
   logic reject_reg;
   logic busy_reg;
   logic meas_start_reg;
   lcj_port_type port_reg;
   logic [31:0] hold_cnt_reg;

   logic editing, step, slot_ok, do_load, do_save, any_en;
   logic [1:0] lim_idx;
   assign editing = !(state_reg inside {st_idle, st_save});
   assign step = editing && (cmd[CMD_CONFIRM] || cmd[CMD_SKIP]);
   assign slot_ok = used_reg[slot_reg];
   assign do_load = cmd[CMD_LOAD] && state_reg == st_idle && slot_ok && !pf_s;
   // only confirm writes a slot; cancel leaves memory alone
   assign do_save = state_reg == st_save && cmd[CMD_CONFIRM] && !pf_s;
   assign any_en = !(lim_reg[0].off && lim_reg[1].off && lim_reg[2].off && lim_reg[3].off);
   always_comb begin
      unique case (state_reg)
         st_main_lower_edit: lim_idx = 2'h1;
         st_second_upper_edit: lim_idx = 2'h2;
         st_second_lower_edit: lim_idx = 2'h3;
         default: lim_idx = 2'h0;
      endcase
   end

   // lowest unused slot, else the first one
   function automatic logic [SLOT_W-1:0] first_free(logic [SLOT_COUNT:SLOT_FIRST] u);
      logic [SLOT_W-1:0] r;
      r = SLOT_W'(SLOT_FIRST);
      for (int i = SLOT_COUNT; i >= SLOT_FIRST; i--) begin
         if (!u[i]) r = SLOT_W'(i);
      end
      return r;
   endfunction

   // edit and save sequence
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg <= st_idle;
         edit_end_reg <= 1'b0;
      end else begin
         edit_end_reg <= 1'b0;
         if (pf_s) begin
            state_reg <= st_idle;
         end else begin
            unique case (state_reg)
               st_idle: begin
                  if (cmd[CMD_EDIT] && !comp_mode_reg) begin
                     state_reg <= st_main_upper_edit;
                  end else if (cmd[CMD_SAVE]) begin
                     state_reg <= st_save;
                  end
               end
               st_main_upper_edit: if (step) state_reg <= st_main_lower_edit;
               st_main_lower_edit: if (step) state_reg <= st_second_upper_edit;
               st_second_upper_edit: if (step) state_reg <= st_second_lower_edit;
               st_second_lower_edit: begin
                  if (step) begin
                     state_reg <= st_idle;
                     edit_end_reg <= 1'b1;
                  end
               end
               st_save: if (cmd[CMD_CONFIRM] || cmd[CMD_CANCEL]) state_reg <= st_idle;
               default: state_reg <= st_idle;
            endcase
         end
      end
   end

   // stored limits; no range or order check on store
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lim_reg <= {4{LIMIT_OFF}};
      end else if (do_load) begin
         lim_reg <= slot_mem[slot_reg].lim;
      end else if (editing && cmd[CMD_CONFIRM] && !pf_s) begin
         lim_reg[lim_idx] <= edit_reg;
      end
   end

   // end hold on the digit-move key turns the edit value off
   logic hold_hit;
   assign hold_hit = hold_cnt_reg == 32'(HOLD_CYCLES - 1);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hold_cnt_reg <= '0;
      end else if (!(editing && sy2_reg[PIN_MOVE] && sy2_reg[PIN_END])) begin
         hold_cnt_reg <= '0;
      end else if (!hold_hit) begin
         hold_cnt_reg <= hold_cnt_reg + 32'h1;
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         edit_reg <= LIMIT_OFF;
      end else if (hold_hit) begin
         edit_reg <= LIMIT_OFF;
      end else if (w_edit && !comp_mode_reg) begin
         edit_reg <= lcj_limit_type'(hwdata[COUNT_W:0]);
      end
   end

   // conditions and mode; comparator mode kept across power loss
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         comp_mode_reg <= 1'b0;
      end else if (edit_end_reg) begin
         comp_mode_reg <= any_en;
      end else if (cmd[CMD_MODE] && state_reg == st_idle && !pf_s) begin
         comp_mode_reg <= !comp_mode_reg;
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg_reg <= '0;
      end else if (do_load) begin
         cfg_reg <= slot_mem[slot_reg].cfg;
      end else if (cmd[CMD_TRIG]) begin
         cfg_reg.outside_trigger <= !cfg_reg.outside_trigger;
      end else if (w_cfg) begin
         cfg_reg.outside_trigger <= hwdata[1];
         if (!comp_mode_reg) cfg_reg.auto_range <= hwdata[0];
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         comp_reg <= '0;
      end else if (do_load) begin
         comp_reg <= slot_mem[slot_reg].comp;
      end else if (w_comp && !comp_mode_reg) begin
         comp_reg <= hwdata;
      end
   end
   assign range_auto_eff = cfg_reg.auto_range && !comp_mode_reg;

   // rejected condition change, sticky, write one to clear; set wins
   logic rej_ev;
   assign rej_ev = comp_mode_reg && (w_comp || w_edit || cmd[CMD_EDIT]
                   || (w_cfg && hwdata[0] != cfg_reg.auto_range));
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         reject_reg <= 1'b0;
      end else if (rej_ev) begin
         reject_reg <= 1'b1;
      end else if (w_stat && hwdata[STAT_REJECT]) begin
         reject_reg <= 1'b0;
      end
   end

   // slot store; the memory itself is battery backed, so unreset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         slot_reg <= SLOT_W'(SLOT_FIRST);
      end else if (cmd[CMD_SAVE] && state_reg == st_idle) begin
         slot_reg <= first_free(used_reg);
      end else if (w_slot && hwdata[SLOT_W-1:0] >= SLOT_W'(SLOT_FIRST)
                   && hwdata[SLOT_W-1:0] <= SLOT_W'(SLOT_COUNT)) begin
         slot_reg <= hwdata[SLOT_W-1:0];
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         used_reg <= '0;
      end else if (do_save) begin
         used_reg[slot_reg] <= 1'b1;
      end
   end
   always_ff @(posedge hclk) begin
      if (do_save) begin
         slot_mem[slot_reg] <= '{cfg: cfg_reg, comp: comp_reg, lim: lim_reg};
      end
   end

   // trigger control; a trigger while busy is dropped
   logic shot, start_now;
   assign shot = cfg_reg.outside_trigger && (cmd[CMD_SHOT] || trig_edge);
   assign start_now = !busy_reg && !pf_s && (!cfg_reg.outside_trigger || shot);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         busy_reg <= 1'b0;
         meas_start_reg <= 1'b0;
      end else begin
         meas_start_reg <= start_now;
         if (start_now) begin
            busy_reg <= 1'b1;
         end else if (meas_done || pf_s) begin
            busy_reg <= 1'b0;
         end
      end
   end
   assign meas_start = meas_start_reg;

   // judgment of both parameters
   lcj_judg_type j_main, j_sec;
   logic act_main, act_sec, update;
   lcj_judge u_judge_main (
      .res(meas_main),
      .upper(lim_reg[0]),
      .lower(lim_reg[1]),
      .judg(j_main),
      .active(act_main)
   );
   lcj_judge u_judge_sec (
      .res(meas_sec),
      .upper(lim_reg[2]),
      .lower(lim_reg[3]),
      .judg(j_sec),
      .active(act_sec)
   );
   assign update = meas_done && comp_mode_reg && (act_main || act_sec);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         port_reg <= '0;
      end else if (!comp_mode_reg) begin
         port_reg <= '0;
      end else if (update) begin
         port_reg <= '{main_j: j_main, sec_j: j_sec,
                      all_pass: j_main.pass && j_sec.pass};
      end
   end
   assign parallel_judgment_port = port_reg;

   // register read mux
   always_comb begin
      rd_word = '0;
      if (haddr[7:0] == OFS_CFG) rd_word = {29'h0, comp_mode_reg, cfg_reg};
      if (haddr[7:0] == OFS_EDIT) rd_word = 32'(edit_reg);
      if (haddr[7:0] == OFS_SLOT) rd_word = {23'h0, slot_ok, 1'b0, slot_reg};
      if (haddr[7:0] == OFS_COMP) rd_word = comp_reg;
      if (haddr[7:0] == OFS_STATUS) begin
         rd_word = {22'h0, range_auto_eff, reject_reg, 1'b0, busy_reg, state_reg};
      end
      if (haddr[7:0] >= OFS_LIM0 && haddr[7:0] <= OFS_LIM3 && haddr[1:0] == 2'h0) begin
         rd_word = 32'(lim_reg[2'(haddr[7:2] - OFS_LIM0[7:2])]);
      end
      if (haddr[7:0] == OFS_JUDGE) rd_word = 32'(port_reg);
   end

   // checks
   chk_judge_hold: assert property (@(posedge hclk) disable iff (!hresetn)
      comp_mode_reg && !update && $past(comp_mode_reg) |=> $stable(port_reg))
      else $error("judgment changed without a measurement");
   chk_judge_fresh: assert property (@(posedge hclk) disable iff (!hresetn)
      update && !pf_s |=> port_reg.main_j == $past(j_main) && port_reg.sec_j == $past(j_sec))
      else $error("judgment not refreshed");
   chk_and_pass: assert property (@(posedge hclk) disable iff (!hresetn)
      port_reg.all_pass |-> port_reg.main_j.pass && port_reg.sec_j.pass)
      else $error("combined pass without both passes");
   chk_range_held: assert property (@(posedge hclk) disable iff (!hresetn)
      comp_mode_reg |-> !range_auto_eff)
      else $error("auto ranging in comparator mode");
   chk_one_start: assert property (@(posedge hclk) disable iff (!hresetn)
      meas_start_reg && !meas_done |=> !meas_start_reg)
      else $error("two starts for one trigger");
   chk_skip_keep: assert property (@(posedge hclk) disable iff (!hresetn)
      editing && cmd[CMD_SKIP] && !cmd[CMD_CONFIRM] |=> $stable(lim_reg))
      else $error("skip changed a stored limit");
   chk_edit_order: assert property (@(posedge hclk) disable iff (!hresetn)
      state_reg == st_main_upper_edit && step && !pf_s |=> state_reg == st_main_lower_edit)
      else $error("edit did not advance");
   chk_power_mode: assert property (@(posedge hclk) disable iff (!hresetn)
      pf_s |=> comp_mode_reg == $past(comp_mode_reg))
      else $error("power loss changed comparator mode");
   chk_ovf_first: assert property (@(posedge hclk) disable iff (!hresetn)
      act_main && meas_main.ovf |-> j_main.over_max && !j_main.pass)
      else $error("overflow not judged over_max");
   chk_lower_strict: assert property (@(posedge hclk) disable iff (!hresetn)
      act_main && !meas_main.ovf && !meas_main.unf && !lim_reg[1].off
      && meas_main.count == lim_reg[1].val |-> j_main.under_min)
      else $error("result on lower limit not under_min");
endmodule

/* sim/lcj_engine_model.sv */
// measurement engine model facing the comparator
// assumes hclk domain; bench sets results and latency
`timescale 1ns/100ps
module lcj_engine_model (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // measurement handshake
   input wire logic meas_start,
   output logic meas_done,
   output lcj_pkg::lcj_result_type meas_main,
   output lcj_pkg::lcj_result_type meas_sec,
   // bench control
   input wire lcj_pkg::lcj_result_type want_main,
   input wire lcj_pkg::lcj_result_type want_sec,
   input wire logic [4:0] lag
);
   import lcj_pkg::*;
   int cnt;
   logic run;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         run <= 1'b0;
         cnt <= 0;
         meas_done <= 1'b0;
         meas_main <= '0;
         meas_sec <= '0;
      end else begin
         meas_done <= 1'b0;
         // results are only valid with done, so scramble them otherwise
         meas_main <= ~meas_main;
         meas_sec <= ~meas_sec;
         if (meas_start) begin
            run <= 1'b1;
            cnt <= 0;
         end else if (run && cnt >= int'(lag)) begin
            run <= 1'b0;
            meas_done <= 1'b1;
            meas_main <= want_main;
            meas_sec <= want_sec;
         end else if (run) begin
            cnt <= cnt + 1;
         end
      end
   end
endmodule

/* sim/lcj_top_tb.sv */
// self-checking bench for the limit comparator
// assumes the engine model on the far side and an ahb-lite master here
`timescale 1ns/100ps
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin n_errors++; \
   $display("unexpected %s expected %h seen %h", nm, e, a); end end
module lcj_top_tb;
   import lcj_pkg::*;
   localparam logic [17:0] L0 = 18'd1000, L1 = 18'd100, L2 = 18'h20000, L3 = 18'd50;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, rd_dp = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, ex;
   logic [1:0] htrans = 0;
   logic hreadyout, hresp, meas_done, meas_start, range_auto_eff;
   logic trig_n = 1, key_move = 0, cursor_at_end = 0, power_fail = 0;
   logic [4:0] lag = 5'd3;
   logic [6:0] pe;
   lcj_result_type mm, ms, wm = '0, ws = '0, tm, ts;
   lcj_port_type port;
   logic [18:0] mt[6] = '{19'h001f4, 19'h003e8, 19'h00064, 19'h401f4, 19'h201f4, 19'h0};
   logic [18:0] st[6] = '{19'h0003c, 19'h00032, 19'h186a0, 19'h2003c, 19'h00033, 19'h0};
   logic [31:0] expq[$];
   int n_errors = 0, n_checks = 0;
   int n_starts = 0, n_st0;
   logic [6:0] portq[$];
   logic [6:0] pq;
   logic done_d = 0;
   initial forever #5 hclk = ~hclk;
   lcj_top #(.HOLD_CYCLES(20)) lcj_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .meas_main(mm), .meas_sec(ms), .meas_done(meas_done), .meas_start(meas_start),
      .range_auto_eff(range_auto_eff), .outside_trigger_n(trig_n), .key_move(key_move),
      .cursor_at_end(cursor_at_end), .power_fail(power_fail),
      .parallel_judgment_port(port));
   lcj_engine_model lcj_engine_model_inst (.hclk(hclk), .hresetn(hresetn),
      .meas_start(meas_start), .meas_done(meas_done), .meas_main(mm), .meas_sec(ms),
      .want_main(wm), .want_sec(ws), .lag(lag));
   // read data is compared at the data phase edge
   always @(posedge hclk) begin
      if (rd_dp && hreadyout === 1'b1) begin
         ex = expq.pop_front();
         `CHK("hrdata", ex, hrdata)
         `CHK("hresp", 1'b0, hresp)
      end
   end
   always @(posedge hclk) if (meas_start === 1'b1) n_starts++;
   // port compared one edge after the done is taken, oldest note first
   always @(posedge hclk) begin
      if (done_d && portq.size() > 0) begin
         pq = portq.pop_front();
         `CHK("port", pq, port)
      end
      done_d <= (meas_done === 1'b1);
   end
   task report_and_stop;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic await_sig(input bit done_sig);
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while ((done_sig ? meas_done : hreadyout) !== 1'b1 && n < 300);
      if ((done_sig ? meas_done : hreadyout) !== 1'b1) begin
         n_errors++;
         report_and_stop();
      end
   endtask
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {24'h0, a};
      await_sig(0);
      htrans <= 2'b00;
      hwdata <= d;
      rd_dp <= !w;
      await_sig(0);
      rd_dp <= 1'b0;
      hsel <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      ahb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      expq.push_back(e);
      ahb(1'b0, a, 32'h0);
   endtask
   task automatic pf;
      @(posedge hclk);
      power_fail <= 1'b1;
      repeat (4) @(posedge hclk);
      power_fail <= 1'b0;
      repeat (4) @(posedge hclk);
   endtask
   function automatic logic [2:0] jd(lcj_result_type r, logic [17:0] up, logic [17:0] lo);
      if (up[17] && lo[17]) return 3'b000;
      if (r.ovf) return 3'b100;
      if (r.unf) return 3'b001;
      if (!lo[17] && !(r.count > lo[16:0])) return 3'b001;
      if (!up[17] && !(r.count < up[16:0])) return 3'b100;
      return 3'b010;
   endfunction
   initial begin
      repeat (100000) @(posedge hclk);
      n_errors++;
      report_and_stop();
   end
   initial begin
      void'($urandom(32'h51e64c09));
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
      rd(OFS_LIM0, 32'h20000);
      rd(8'h40, 32'h0);
      rd(OFS_JUDGE, 32'h0);
      wr(OFS_COMP, 32'h1234);
      wr(OFS_CFG, 32'h3);
      #1 `CHK("range_auto_eff", 1'b1, range_auto_eff)
      repeat (40) @(posedge hclk);
      $display("test reboot done");
      wr(OFS_CMD, 32'h8);
      wr(OFS_EDIT, {14'h0, L0});
      wr(OFS_CMD, 32'h10);
      wr(OFS_EDIT, {14'h0, L1});
      wr(OFS_CMD, 32'h10);
      key_move <= 1'b1;
      cursor_at_end <= 1'b1;
      repeat (30) @(posedge hclk);
      key_move <= 1'b0;
      cursor_at_end <= 1'b0;
      wr(OFS_CMD, 32'h10);
      wr(OFS_EDIT, {14'h0, L3});
      wr(OFS_CMD, 32'h10);
      rd(OFS_LIM0, {14'h0, L0});
      rd(OFS_LIM0 + 8'h04, {14'h0, L1});
      rd(OFS_LIM0 + 8'h08, {14'h0, L2});
      rd(OFS_LIM3, {14'h0, L3});
      rd(OFS_CFG, 32'h7);
      #1 `CHK("range_auto_eff", 1'b0, range_auto_eff)
      $display("test edit done");
      for (int i = 0; i < 6; i++) begin
         tm = mt[i];
         ts = st[i];
         if (i == 5) begin
            tm.count = 17'(101 + $urandom % 899);
            ts.count = 17'(51 + $urandom % 100000);
         end
         wm <= tm;
         ws <= ts;
         lag <= 5'($urandom % 30 + 1);
         pe = {jd(tm, L0, L1), jd(ts, L2, L3), 1'b0};
         pe[0] = pe[5] & pe[2];
         portq.push_back(pe);
         n_st0 = n_starts;
         if (i % 2 == 1) begin
            @(posedge hclk);
            trig_n <= 1'b0;
            repeat (3) @(posedge hclk);
            trig_n <= 1'b1;
         end else wr(OFS_CMD, 32'h4);
         await_sig(1);
         @(posedge hclk);
         #1 `CHK("starts", n_st0 + 1, n_starts)
         rd(OFS_JUDGE, {25'h0, pe});
      end
      $display("test judge done");
      wr(OFS_COMP, 32'hff);
      rd(OFS_COMP, 32'h1234);
      rd(OFS_STATUS, 32'h101);
      wr(OFS_STATUS, 32'h100);
      pf();
      rd(OFS_CFG, 32'h7);
      wr(OFS_CMD, 32'h1);
      wr(OFS_CMD, 32'h8);
      wr(OFS_EDIT, 32'h7);
      pf();
      rd(OFS_LIM0, {14'h0, L0});
      rd(OFS_STATUS, 32'h201);
      wr(OFS_CMD, 32'h8);
      repeat (4) wr(OFS_CMD, 32'h20);
      rd(OFS_LIM0 + 8'h04, {14'h0, L1});
      rd(OFS_CFG, 32'h7);
      $display("test reject power skip done");
      wr(OFS_CMD, 32'h40);
      rd(OFS_SLOT, 32'h1);
      wr(OFS_CMD, 32'h10);
      wr(OFS_CMD, 32'h40);
      rd(OFS_SLOT, 32'h2);
      wr(OFS_CMD, 32'h100);
      rd(OFS_SLOT, 32'h2);
      wr(OFS_SLOT, 32'h1);
      rd(OFS_SLOT, 32'h101);
      wr(OFS_CMD, 32'h2);
      rd(OFS_CFG, 32'h5);
      wr(OFS_CMD, 32'h80);
      rd(OFS_CFG, 32'h7);
      $display("test slots done");
      report_and_stop();
   end
endmodule
